// ---- dio_pkg.sv ----
// constants, object map and carrier types of the drive io/mode bank
// Overview of operation
// - input function codes: 2 positive limit, 8 e-stop, 64 probe two
// - reset selects: in1 probe one, in2 homing, in3 pos, in4 neg, in5 user
// - per-input debounce 50..60000 us, default 1000; change must hold
// - polarity word, bit0 is input one, 1 inverts, resets to 0
// - read-only input state word, bit0 is input one, resets to 0
// - after enable, wait 0..3000 ms (default 50), then free brake
// - after disable, wait engage delay 0..3000 ms (default 50) to stop pwm
// - mode 1 position, 3 velocity, 6 homing, 8 cyclic sync; reset 8
// - quick-stop code is 5 (slow ramp then hold); other values refused
// - no-motion reason: 23 unsupported mode, 30 velocity over range
// - position mode in-place source: 0 planner done, 10 drive; default 0
// - ten alarm entries, first is newest, each limited to 0..32767
// - read-only last error code shows newest error, resets to 0
package dio_pkg;
   localparam int DIO_NUM_IN = 5;
   localparam int DIO_NUM_ALARM = 10;
   // timing
   localparam int DIO_CLK_PERIOD_NS = 100;
   localparam int DIO_US_NS = 1000;
   localparam int DIO_MS_US = 1000;
   localparam int DIO_CYC_PER_US = DIO_US_NS / DIO_CLK_PERIOD_NS;
   // object indices
   localparam logic [15:0] IDX_FUNC_SEL = 16'h2152;
   localparam logic [15:0] IDX_FILTER = 16'h2153;
   localparam logic [15:0] IDX_POLARITY = 16'h2154;
   localparam logic [15:0] IDX_IN_STATE = 16'h2155;
   localparam logic [15:0] IDX_INPLACE_SRC = 16'h2163;
   localparam logic [15:0] IDX_FW_VER = 16'h3100;
   localparam logic [15:0] IDX_ALARM_LIST = 16'h3FFE;
   localparam logic [15:0] IDX_BRAKE_REL = 16'h4003;
   localparam logic [15:0] IDX_BRAKE_ENG = 16'h4004;
   localparam logic [15:0] IDX_INT_ENABLE = 16'h5001;
   localparam logic [15:0] IDX_SLV_CTRL = 16'h5002;
   localparam logic [15:0] IDX_SLV_DATA = 16'h5003;
   localparam logic [15:0] IDX_WD_COUNT = 16'h5004;
   localparam logic [15:0] IDX_WD_TIME = 16'h5010;
   localparam logic [15:0] IDX_NO_MOTION = 16'h5013;
   localparam logic [15:0] IDX_VEL_LIMIT = 16'h5014;
   localparam logic [15:0] IDX_LAST_ERR = 16'h603F;
   localparam logic [15:0] IDX_CTRL_WORD = 16'h6040;
   localparam logic [15:0] IDX_STATE_WORD = 16'h6041;
   localparam logic [15:0] IDX_QUICK_STOP = 16'h605A;
   localparam logic [15:0] IDX_OP_MODE = 16'h6060;
   // input function codes
   localparam logic [15:0] FN_HOMING = 16'h0001;
   localparam logic [15:0] FN_POS_LIMIT = 16'h0002;
   localparam logic [15:0] FN_NEG_LIMIT = 16'h0004;
   localparam logic [15:0] FN_ESTOP = 16'h0008;
   localparam logic [15:0] FN_USER = 16'h0010;
   localparam logic [15:0] FN_PROBE1 = 16'h0020;
   localparam logic [15:0] FN_PROBE2 = 16'h0040;
   // reset values and ranges
   localparam logic [15:0] FUNC_RST [DIO_NUM_IN] =
      '{16'h0020, 16'h0001, 16'h0002, 16'h0004, 16'h0010};
   localparam logic [15:0] FILTER_RST = 16'h03E8;
   localparam logic [15:0] FILTER_MIN = 16'h0032;
   localparam logic [15:0] FILTER_MAX = 16'hEA60;
   localparam logic [15:0] BRAKE_RST = 16'h0032;
   localparam logic [15:0] BRAKE_MAX = 16'h0BB8;
   localparam logic [15:0] VEL_LIMIT_RST = 16'h0640;
   localparam logic [15:0] VEL_LIMIT_MAX = 16'h0BB8;
   localparam logic [15:0] QUICK_STOP_RST = 16'h0005;
   localparam logic [15:0] INPLACE_PLAN = 16'h0000;
   localparam logic [15:0] INPLACE_DRIVE = 16'h000A;
   localparam logic [15:0] ALARM_MAX = 16'h7FFF;
   // operating modes and no-motion reasons
   localparam logic [7:0] MODE_POSITION = 8'h01;
   localparam logic [7:0] MODE_VELOCITY = 8'h03;
   localparam logic [7:0] MODE_HOMING = 8'h06;
   localparam logic [7:0] MODE_CYCLIC_SYNC_POSITION = 8'h08;
   localparam logic [7:0] MODE_RST = 8'h08;
   localparam logic [15:0] REASON_NONE = 16'h0000;
   localparam logic [15:0] REASON_MODE = 16'h0017;
   localparam logic [15:0] REASON_VELOCITY = 16'h001E;

   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] index;
      logic [7:0] subindex;
      logic [15:0] wdata;
   } dio_req_t;

   typedef struct packed {
      logic valid;
      logic err;
      logic [15:0] rdata;
   } dio_rsp_t;

   typedef struct packed {
      logic homing;
      logic pos_limit;
      logic neg_limit;
      logic estop;
      logic probe1;
      logic probe2;
      logic [DIO_NUM_IN-1:0] user;
   } dio_func_t;
endpackage

// ---- dio_alarm_hist.sv ----
// alarm history store, newest entry first, registered read
`timescale 1ns/10ps
module dio_alarm_hist #(
   parameter int DEPTH = 10,
   parameter int WIDTH = 15
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // new alarm, shifts the history down
   input wire logic push,
   input wire logic [WIDTH-1:0] push_data,
   // direct entry write
   input wire logic wr_en,
   input wire logic [3:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   // read port
   input wire logic [3:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] entry [DEPTH];

   if (DEPTH < 1 || DEPTH > 16) begin : g_chk
      $error("dio_alarm_hist: DEPTH must be 1..16");
   end

   for (genvar k = 0; k < DEPTH; k++)
   begin : g_ent
      // a push beats a direct write to keep the newest alarm
      always_ff @(posedge clk)
      begin
         if (!nrst)
            entry[k] <= '0;
         else if (push)
            entry[k] <= (k == 0) ? push_data : entry[(k == 0) ? 0 : k - 1];
         else if (wr_en && wr_addr == 4'(k))
            entry[k] <= wr_data;
      end
   end

   wire rd_in_range = int'(rd_addr) < DEPTH;

   always_ff @(posedge clk)
   begin
      if (!nrst)
         rd_data <= '0;
      else
         rd_data <= rd_in_range ? entry[rd_addr] : '0;
   end
endmodule

// ---- dio_bank.sv ----
// io, brake and mode object bank of the stepper drive
`timescale 1ns/10ps
module dio_bank
   import dio_pkg::*;
#(
   parameter int TICKS_PER_US = dio_pkg::DIO_CYC_PER_US,
   parameter int US_PER_MS = dio_pkg::DIO_MS_US,
   parameter logic [15:0] FW_DRIVE_VER = 16'h0001, // arbitrary value
   parameter logic [15:0] FW_LOGIC_VER = 16'h0002, // arbitrary value
   parameter logic [15:0] FW_BUS_VER = 16'h0003 // arbitrary value
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // object access from the fieldbus side
   input dio_pkg::dio_req_t req,
   output dio_pkg::dio_rsp_t rsp,
   // digital input pins
   input wire logic [dio_pkg::DIO_NUM_IN-1:0] din_pin,
   // status from the motion core
   input wire logic drive_enable,
   input wire logic plan_done,
   input wire logic drive_inplace,
   input wire logic [15:0] cmd_velocity,
   input wire logic [15:0] state_word_in,
   input wire logic [15:0] slave_data_in,
   input wire logic [15:0] watchdog_count_in,
   input wire logic alarm_valid,
   input wire logic [14:0] alarm_code,
   input wire logic error_valid,
   input wire logic [15:0] error_code_in,
   // decoded input functions
   output dio_pkg::dio_func_t func_out,
   // brake and power stage
   output logic brake_release,
   output logic pwm_on,
   // motion settings
   output logic in_place,
   output logic quick_stop_slow,
   output logic [7:0] mode_out,
   output logic [15:0] control_word_out,
   output logic [15:0] slave_ctrl_out,
   output logic [15:0] watchdog_time_out,
   output logic [15:0] velocity_limit_out,
   // nonvolatile store request
   output logic store_req,
   output logic [15:0] store_index
);
   import dio_pkg::*;

   if (TICKS_PER_US < 1 || TICKS_PER_US > 65535) begin : g_chk_us
      $error("dio_bank: TICKS_PER_US must be 1..65535");
   end
   if (US_PER_MS < 1 || US_PER_MS > 65535) begin : g_chk_ms
      $error("dio_bank: US_PER_MS must be 1..65535");
   end

   typedef enum logic [1:0] {ST_OFF, ST_REL_WAIT, ST_RUN, ST_ENG_WAIT}
      dio_brake_t;

   // parameter storage
   logic [15:0] func_sel [DIO_NUM_IN];
   logic [15:0] filter_time [DIO_NUM_IN];
   logic [15:0] polarity;
   logic [15:0] inplace_src;
   logic [15:0] brake_rel_dly;
   logic [15:0] brake_eng_dly;
   logic [15:0] quick_stop_code;
   logic [15:0] last_error;
   logic [15:0] no_motion;
   logic [DIO_NUM_IN-1:0] in_state;

   // time base
   logic [15:0] us_div;
   logic [15:0] ms_div;
   logic [15:0] ms_cnt;
   wire us_tick = us_div == 16'(TICKS_PER_US - 1);

   always_ff @(posedge clk)
   begin
      if (!nrst)
         us_div <= 16'h0000;
      else
         us_div <= us_tick ? 16'h0000 : us_div + 16'h0001;
   end

   // pin synchronisers and debounce filters
   logic [DIO_NUM_IN-1:0] pin_s1;
   logic [DIO_NUM_IN-1:0] pin_s2;

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         pin_s1 <= '0;
         pin_s2 <= '0;
      end
      else
      begin
         pin_s1 <= din_pin;
         pin_s2 <= pin_s1;
      end
   end

   for (genvar i = 0; i < DIO_NUM_IN; i++)
   begin : g_in
      logic [15:0] stable_us;
      logic filt;
      wire level = pin_s2[i] ^ polarity[i];
      wire done = {1'b0, stable_us} + 17'h00001 >= {1'b0, filter_time[i]};

      // change accepted only after holding for the filter time
      always_ff @(posedge clk)
      begin
         if (!nrst)
         begin
            stable_us <= 16'h0000;
            filt <= 1'b0;
         end
         else if (level == filt)
            stable_us <= 16'h0000;
         else if (us_tick && done)
         begin
            filt <= level;
            stable_us <= 16'h0000;
         end
         else if (us_tick)
            stable_us <= stable_us + 16'h0001;
      end
      assign in_state[i] = filt;
   end

   // input function decode
   dio_func_t next_func;

   always_comb
   begin
      next_func = '0;
      for (int i = 0; i < DIO_NUM_IN; i++)
      begin
         if (in_state[i])
         begin
            next_func.homing |= func_sel[i] == FN_HOMING;
            next_func.pos_limit |= func_sel[i] == FN_POS_LIMIT;
            next_func.neg_limit |= func_sel[i] == FN_NEG_LIMIT;
            next_func.estop |= func_sel[i] == FN_ESTOP;
            next_func.probe1 |= func_sel[i] == FN_PROBE1;
            next_func.probe2 |= func_sel[i] == FN_PROBE2;
            next_func.user[i] = func_sel[i] == FN_USER;
         end
      end
   end

   // request decode
   wire [15:0] wd = req.wdata;
   wire [7:0] sub = req.subindex;
   wire sub0 = sub == 8'h00;
   wire sub_in = sub >= 8'h01 && sub <= 8'(DIO_NUM_IN);
   wire sub_fw = sub >= 8'h01 && sub <= 8'h03;
   wire sub_al = sub >= 8'h01 && sub <= 8'(DIO_NUM_ALARM);
   wire [2:0] in_idx = sub_in ? 3'(sub - 8'h01) : 3'h0;
   wire [3:0] al_idx = sub_al ? 4'(sub - 8'h01) : 4'h0;
   wire func_ok = wd == 16'h0000 || wd == FN_HOMING || wd == FN_POS_LIMIT ||
      wd == FN_NEG_LIMIT || wd == FN_ESTOP || wd == FN_USER ||
      wd == FN_PROBE1 || wd == FN_PROBE2;
   wire filt_ok = wd >= FILTER_MIN && wd <= FILTER_MAX;
   wire brake_ok = wd <= BRAKE_MAX;
   wire inpl_ok = wd == INPLACE_PLAN || wd == INPLACE_DRIVE;
   wire qs_ok = wd == QUICK_STOP_RST;
   wire mode_ok = wd[15:8] == 8'h00;
   wire vlim_ok = wd <= VEL_LIMIT_MAX;
   wire alarm_ok = wd <= ALARM_MAX;
   wire [14:0] alarm_rd;
   logic acc_err;
   logic is_alarm;
   logic [15:0] rd_val;

   always_comb
   begin
      acc_err = 1'b0;
      is_alarm = 1'b0;
      rd_val = 16'h0000;
      unique case (req.index)
         IDX_FUNC_SEL:
         begin
            acc_err = !sub_in || (req.write && !func_ok);
            rd_val = func_sel[in_idx];
         end
         IDX_FILTER:
         begin
            acc_err = !sub_in || (req.write && !filt_ok);
            rd_val = filter_time[in_idx];
         end
         IDX_POLARITY:
         begin
            acc_err = !sub0;
            rd_val = polarity;
         end
         IDX_INPLACE_SRC:
         begin
            acc_err = !sub0 || (req.write && !inpl_ok);
            rd_val = inplace_src;
         end
         IDX_ALARM_LIST:
         begin
            acc_err = !sub_al || (req.write && !alarm_ok);
            is_alarm = 1'b1;
         end
         IDX_BRAKE_REL:
         begin
            acc_err = !sub0 || (req.write && !brake_ok);
            rd_val = brake_rel_dly;
         end
         IDX_BRAKE_ENG:
         begin
            acc_err = !sub0 || (req.write && !brake_ok);
            rd_val = brake_eng_dly;
         end
         IDX_QUICK_STOP:
         begin
            acc_err = !sub0 || (req.write && !qs_ok);
            rd_val = quick_stop_code;
         end
         IDX_OP_MODE:
         begin
            acc_err = !sub0 || (req.write && !mode_ok);
            rd_val = {8'h00, mode_out};
         end
         IDX_VEL_LIMIT:
         begin
            acc_err = !sub0 || (req.write && !vlim_ok);
            rd_val = velocity_limit_out;
         end
         IDX_CTRL_WORD:
         begin
            acc_err = !sub0;
            rd_val = control_word_out;
         end
         IDX_SLV_CTRL:
         begin
            acc_err = !sub0;
            rd_val = slave_ctrl_out;
         end
         IDX_WD_TIME:
         begin
            acc_err = !sub0;
            rd_val = watchdog_time_out;
         end
         IDX_FW_VER:
         begin
            acc_err = !sub_fw || req.write;
            rd_val = sub == 8'h01 ? FW_DRIVE_VER :
               sub == 8'h02 ? FW_LOGIC_VER : FW_BUS_VER;
         end
         // read-only objects refuse any write
         IDX_IN_STATE:
         begin
            acc_err = !sub0 || req.write;
            rd_val = 16'(in_state);
         end
         IDX_INT_ENABLE:
         begin
            acc_err = !sub0 || req.write;
            rd_val = {15'h0000, pwm_on};
         end
         IDX_SLV_DATA:
         begin
            acc_err = !sub0 || req.write;
            rd_val = slave_data_in;
         end
         IDX_WD_COUNT:
         begin
            acc_err = !sub0 || req.write;
            rd_val = watchdog_count_in;
         end
         IDX_NO_MOTION:
         begin
            acc_err = !sub0 || req.write;
            rd_val = no_motion;
         end
         IDX_LAST_ERR:
         begin
            acc_err = !sub0 || req.write;
            rd_val = last_error;
         end
         IDX_STATE_WORD:
         begin
            acc_err = !sub0 || req.write;
            rd_val = state_word_in;
         end
         default:
            acc_err = 1'b1;
      endcase
   end

   wire wr_take = req.valid && req.write && !acc_err;
   wire saved_obj = req.index == IDX_FUNC_SEL || req.index == IDX_FILTER ||
      req.index == IDX_POLARITY || req.index == IDX_INPLACE_SRC ||
      req.index == IDX_ALARM_LIST || req.index == IDX_BRAKE_REL ||
      req.index == IDX_BRAKE_ENG;
   wire alarm_wr = wr_take && req.index == IDX_ALARM_LIST;

   // parameter writes
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         for (int i = 0; i < DIO_NUM_IN; i++)
         begin
            func_sel[i] <= FUNC_RST[i];
            filter_time[i] <= FILTER_RST;
         end
         polarity <= 16'h0000;
         inplace_src <= INPLACE_PLAN;
         brake_rel_dly <= BRAKE_RST;
         brake_eng_dly <= BRAKE_RST;
         quick_stop_code <= QUICK_STOP_RST;
         mode_out <= MODE_RST;
         velocity_limit_out <= VEL_LIMIT_RST;
         control_word_out <= 16'h0000;
         slave_ctrl_out <= 16'h0000;
         watchdog_time_out <= 16'h0000;
      end
      else if (wr_take)
      begin
         unique case (req.index)
            IDX_FUNC_SEL: func_sel[in_idx] <= wd;
            IDX_FILTER: filter_time[in_idx] <= wd;
            IDX_POLARITY: polarity <= wd;
            IDX_INPLACE_SRC: inplace_src <= wd;
            IDX_BRAKE_REL: brake_rel_dly <= wd;
            IDX_BRAKE_ENG: brake_eng_dly <= wd;
            IDX_QUICK_STOP: quick_stop_code <= wd;
            IDX_OP_MODE: mode_out <= wd[7:0];
            IDX_VEL_LIMIT: velocity_limit_out <= wd;
            IDX_CTRL_WORD: control_word_out <= wd;
            IDX_SLV_CTRL: slave_ctrl_out <= wd;
            IDX_WD_TIME: watchdog_time_out <= wd;
            default: ;
         endcase
      end
   end

   dio_alarm_hist #(
      .DEPTH(DIO_NUM_ALARM),
      .WIDTH(15)
   ) u_hist (
      .clk(clk),
      .nrst(nrst),
      .push(alarm_valid),
      .push_data(alarm_code),
      .wr_en(alarm_wr),
      .wr_addr(al_idx),
      .wr_data(wd[14:0]),
      .rd_addr(al_idx),
      .rd_data(alarm_rd)
   );

   // answer two edges after the request so the history read lines up
   logic p_valid;
   logic p_err;
   logic p_alarm;
   logic [15:0] p_data;

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         p_valid <= 1'b0;
         p_err <= 1'b0;
         p_alarm <= 1'b0;
         p_data <= 16'h0000;
         rsp <= '0;
      end
      else
      begin
         p_valid <= req.valid;
         p_err <= req.valid && acc_err;
         p_alarm <= is_alarm;
         p_data <= rd_val;
         rsp.valid <= p_valid;
         rsp.err <= p_err;
         rsp.rdata <= (p_valid && !p_err) ?
            (p_alarm ? {1'b0, alarm_rd} : p_data) : 16'h0000;
      end
   end

   // status and derived outputs
   wire mode_known = mode_out == MODE_POSITION || mode_out == MODE_VELOCITY ||
      mode_out == MODE_HOMING || mode_out == MODE_CYCLIC_SYNC_POSITION;
   wire [15:0] next_no_motion = !mode_known ? REASON_MODE :
      cmd_velocity > velocity_limit_out ? REASON_VELOCITY : REASON_NONE;
   wire next_in_place = mode_out == MODE_POSITION &&
      (inplace_src == INPLACE_DRIVE ? drive_inplace : plan_done);

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         last_error <= 16'h0000;
         no_motion <= REASON_NONE;
         in_place <= 1'b0;
         quick_stop_slow <= 1'b0;
         func_out <= '0;
         store_req <= 1'b0;
         store_index <= 16'h0000;
      end
      else
      begin
         if (error_valid)
            last_error <= error_code_in;
         no_motion <= next_no_motion;
         in_place <= next_in_place;
         quick_stop_slow <= quick_stop_code == QUICK_STOP_RST;
         func_out <= next_func;
         store_req <= wr_take && saved_obj;
         if (wr_take && saved_obj)
            store_index <= req.index;
      end
   end

   // brake sequencing, delays counted in whole ms from state entry
   dio_brake_t state;
   dio_brake_t next_state;
   wire ms_tick = us_tick && ms_div == 16'(US_PER_MS - 1);
   wire rel_done = ms_cnt >= brake_rel_dly;
   wire eng_done = ms_cnt >= brake_eng_dly;

   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_OFF:
            if (drive_enable)
               next_state = ST_REL_WAIT;
         ST_REL_WAIT:
            if (!drive_enable)
               next_state = ST_ENG_WAIT;
            else if (rel_done)
               next_state = ST_RUN;
         ST_RUN:
            if (!drive_enable)
               next_state = ST_ENG_WAIT;
         ST_ENG_WAIT:
            if (drive_enable)
               next_state = ST_REL_WAIT;
            else if (eng_done)
               next_state = ST_OFF;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         state <= ST_OFF;
         ms_div <= 16'h0000;
         ms_cnt <= 16'h0000;
         brake_release <= 1'b0;
         pwm_on <= 1'b0;
      end
      else
      begin
         state <= next_state;
         brake_release <= next_state == ST_RUN;
         pwm_on <= next_state != ST_OFF;
         if (next_state != state)
         begin
            ms_div <= 16'h0000;
            ms_cnt <= 16'h0000;
         end
         else if (ms_tick)
         begin
            ms_div <= 16'h0000;
            ms_cnt <= ms_cnt + 16'h0001;
         end
         else if (us_tick)
            ms_div <= ms_div + 16'h0001;
      end
   end
endmodule

// ---- dio_master.sv ----
// fieldbus master model issuing object requests
`timescale 1ns/10ps
module dio_master (
   // clock
   input wire logic clk,
   // request to the bank
   output dio_pkg::dio_req_t req
);
   import dio_pkg::*;
   initial req = '0;
   // one request, held across exactly one take edge
   task automatic xfer(input logic w, input logic [15:0] i,
      input logic [7:0] s, input logic [15:0] d);
   begin
      @(posedge clk);
      #1 req = '{1'b1, w, i, s, d};
      @(posedge clk);
      // released fields show junk, never the old request
      #1 req = '{1'b0, ~w, ~i, ~s, ~d};
   end
   endtask
endmodule

// ---- dio_bank_checker.sv ----
// assertions on the io/mode bank ports
`timescale 1ns/10ps
module dio_bank_checker (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // object port
   input dio_pkg::dio_req_t req,
   input dio_pkg::dio_rsp_t rsp,
   // drive and outputs
   input wire logic drive_enable,
   input wire logic brake_release,
   input wire logic pwm_on,
   input wire logic quick_stop_slow,
   input wire logic [7:0] mode_out,
   input wire logic store_req,
   input wire logic [15:0] store_index
);
   import dio_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   wire wr_ok = req.valid && req.write && req.subindex == 8'h00;
   sequence s_take;
      req.valid;
   endsequence
   sequence s_answer;
      ##2 rsp.valid;
   endsequence
   a_rsp_two_cycles: assert property (s_take |-> s_answer)
      else $error("answer late or missing");
   a_rsp_has_cause: assert property (rsp.valid
      |-> $past(req.valid, 2))
      else $error("answer without request");
   a_qs_refused: assert property (wr_ok
      && req.index == IDX_QUICK_STOP && req.wdata != QUICK_STOP_RST
      |-> ##2 rsp.err)
      else $error("bad quick-stop code taken");
   a_qs_kept: assert property ($past(nrst) |-> quick_stop_slow)
      else $error("quick-stop code lost");
   a_mode_stored: assert property (wr_ok && req.index == IDX_OP_MODE
      && req.wdata < 16'h0100 |=> mode_out == $past(req.wdata[7:0]))
      else $error("mode not stored");
   a_pwm_on_enable: assert property ($rose(drive_enable) |=> pwm_on)
      else $error("power stage not on");
   a_brake_drop: assert property ($fell(drive_enable)
      |=> !brake_release)
      else $error("brake not engaged");
   a_store_pulse: assert property (wr_ok
      && req.index == IDX_BRAKE_REL
      && req.wdata <= BRAKE_MAX |=> store_req && store_index == IDX_BRAKE_REL)
      else $error("store request missing");
endmodule
bind dio_bank dio_bank_checker chk (.clk(clk), .nrst(nrst), .req(req),
   .rsp(rsp), .drive_enable(drive_enable), .brake_release(brake_release),
   .pwm_on(pwm_on), .quick_stop_slow(quick_stop_slow),
   .mode_out(mode_out), .store_req(store_req), .store_index(store_index));

// ---- dio_tb.sv ----
// self-checking bench of the io/mode object bank
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
   $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module testbench;
   import dio_pkg::*;
   logic clk = 0, nrst = 0, drive_enable = 0, error_valid = 0;
   logic alarm_valid = 0;
   logic [4:0] din_pin = '0, p, d;
   logic [15:0] cmd_velocity = '0, error_code_in = '0, v;
   logic [14:0] alarm_code = '0;
   logic [7:0] s;
   logic [17:0] q[$], e;
   logic brake_release, pwm_on, in_place, plan_done = 0, drive_inplace = 0;
   int errors = 0, checks_done = 0;
   dio_req_t req;
   dio_rsp_t rsp;
   dio_func_t func_out;
   localparam logic [7:0] MD [5] = '{MODE_POSITION, MODE_VELOCITY,
      MODE_HOMING, MODE_CYCLIC_SYNC_POSITION, 8'h02};
   always #50 clk = ~clk;
   dio_master m (.clk(clk), .req(req));
   // short us and ms ticks keep the delays in the tens of cycles
   dio_bank #(.TICKS_PER_US(1), .US_PER_MS(4)) dut (.clk(clk), .nrst(nrst),
      .req(req), .rsp(rsp), .din_pin(din_pin), .drive_enable(drive_enable),
      .plan_done(plan_done), .drive_inplace(drive_inplace),
      .cmd_velocity(cmd_velocity), .state_word_in(16'h0000),
      .slave_data_in(16'h0000),
      .watchdog_count_in(16'h0000), .alarm_valid(alarm_valid),
      .alarm_code(alarm_code), .error_valid(error_valid),
      .error_code_in(error_code_in), .func_out(func_out),
      .brake_release(brake_release), .pwm_on(pwm_on), .in_place(in_place),
      .quick_stop_slow(), .mode_out(), .control_word_out(),
      .slave_ctrl_out(), .watchdog_time_out(), .velocity_limit_out(),
      .store_req(), .store_index());
   task automatic rd(input logic [15:0] i, input logic [7:0] k,
      input logic [15:0] x);
   begin
      q.push_back({2'b10, x});
      m.xfer(1'b0, i, k, 16'h0000);
   end
   endtask
   task automatic wr(input logic [15:0] i, input logic [7:0] k,
      input logic [15:0] x, input logic bad);
   begin
      q.push_back({1'b0, bad, 16'h0000});
      m.xfer(1'b1, i, k, x);
   end
   endtask
   task automatic results;
   begin
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
   endtask
   always @(negedge clk)
      if (rsp.valid === 1'b1)
      begin
         e = q.pop_front();
         `CHK(rsp.err, e[16])
         if (e[17])
            `CHK(rsp.rdata, e[15:0])
      end
   initial
   begin
      #(100 * 8000);
      errors++;
      $display("MISMATCH %0t watchdog", $time);
      results();
   end
   initial
   begin
      v = $urandom(32'hE365D3E7);
      repeat (3) @(posedge clk);
      #1 nrst = 1;
      for (int k = 0; k < 5; k++)
      begin
         rd(IDX_FUNC_SEL, 8'(k + 1), FUNC_RST[k]);
         rd(IDX_FILTER, 8'(k + 1), FILTER_RST);
      end
      rd(IDX_POLARITY, 8'h00, 16'h0000);
      rd(IDX_IN_STATE, 8'h00, 16'h0000);
      rd(IDX_INPLACE_SRC, 8'h00, INPLACE_PLAN);
      rd(IDX_BRAKE_ENG, 8'h00, BRAKE_RST);
      rd(IDX_OP_MODE, 8'h00, 16'h0008);
      rd(IDX_LAST_ERR, 8'h00, 16'h0000);
      $display("test reset values done");
      wr(IDX_QUICK_STOP, 8'h00, 16'h0006, 1);
      wr(IDX_IN_STATE, 8'h00, 16'h0001, 1);
      wr(IDX_FILTER, 8'h01, 16'h0031, 1);
      wr(IDX_FILTER, 8'h02, 16'hEA61, 1);
      wr(IDX_BRAKE_ENG, 8'h00, 16'h0BB9, 1);
      wr(IDX_FUNC_SEL, 8'h01, 16'h0003, 1);
      wr(IDX_INPLACE_SRC, 8'h00, 16'h0005, 1);
      wr(IDX_INPLACE_SRC, 8'h00, INPLACE_DRIVE, 0);
      wr(IDX_ALARM_LIST, 8'h01, 16'h8000, 1);
      rd(IDX_QUICK_STOP, 8'h00, QUICK_STOP_RST);
      rd(IDX_FILTER, 8'h02, FILTER_RST);
      for (int k = 0; k < 7; k++)
      begin
         s = 8'($urandom_range(1, 5));
         wr(IDX_FUNC_SEL, s, 16'h0001 << k, 0);
         rd(IDX_FUNC_SEL, s, 16'h0001 << k);
      end
      $display("test refusals and codes done");
      for (int k = 0; k < 5; k++)
      begin
         wr(IDX_FUNC_SEL, 8'(k + 1), k == 0 ? FN_ESTOP : FN_USER, 0);
         wr(IDX_FILTER, 8'(k + 1), FILTER_MIN, 0);
      end
      p = 5'($urandom);
      d = 5'($urandom);
      wr(IDX_POLARITY, 8'h00, {11'h000, p}, 0);
      din_pin = d;
      // still inside the 50 us stable window
      rd(IDX_IN_STATE, 8'h00, 16'h0000);
      repeat (80) @(posedge clk);
      rd(IDX_IN_STATE, 8'h00, {11'h000, d ^ p});
      `CHK(func_out.estop, d[0] ^ p[0])
      `CHK(func_out.user, {d[4:1] ^ p[4:1], 1'b0})
      $display("test inputs done");
      wr(IDX_BRAKE_REL, 8'h00, 16'h000A, 0);
      wr(IDX_BRAKE_ENG, 8'h00, 16'h0000, 0);
      drive_enable = 1;
      repeat (30) @(posedge clk);
      #1 `CHK(brake_release, 1'b0)
      `CHK(pwm_on, 1'b1)
      repeat (30) @(posedge clk);
      #1 `CHK(brake_release, 1'b1)
      drive_enable = 0;
      drive_inplace = v[0];
      plan_done = ~v[0];
      repeat (4) @(posedge clk);
      #1 `CHK(pwm_on, 1'b0)
      $display("test brake done");
      for (int k = 0; k < 5; k++)
      begin
         wr(IDX_OP_MODE, 8'h00, {8'h00, MD[k]}, 0);
         rd(IDX_NO_MOTION, 8'h00,
            k == 4 ? REASON_MODE : REASON_NONE);
         `CHK(in_place, k == 0 && v[0])
      end
      wr(IDX_OP_MODE, 8'h00, 16'h0008, 0);
      cmd_velocity = 16'h0BB9;
      rd(IDX_NO_MOTION, 8'h00, REASON_VELOCITY);
      v = 16'($urandom);
      error_code_in = v;
      alarm_code = v[14:0];
      error_valid = 1;
      alarm_valid = 1;
      @(posedge clk);
      #1 alarm_code = ~v[14:0];
      error_valid = 0;
      @(posedge clk);
      #1 alarm_valid = 0;
      rd(IDX_LAST_ERR, 8'h00, v);
      rd(IDX_ALARM_LIST, 8'h01, {1'b0, ~v[14:0]});
      rd(IDX_ALARM_LIST, 8'h02, {1'b0, v[14:0]});
      wr(IDX_CTRL_WORD, 8'h00, v, 0);
      rd(IDX_CTRL_WORD, 8'h00, v);
      repeat (6) @(posedge clk);
      `CHK(q.size(), 0)
      $display("test modes and history done");
      results();
   end
endmodule
